// ==== verilog/flash_seq_pkg.sv ====
// constants, command codes and carrier types of the flash program/erase sequencer
// assumes a 250 MHz system clock that oversamples the serial link
package flash_seq_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 4;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
	localparam logic [7:0] READ_STATUS_CMD = 8'h05;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] QUAD_PROGRAM_CMD = 8'h32;
	localparam logic [7:0] SECTOR_ERASE_CMD = 8'h20;
	localparam logic [7:0] HALF_BLOCK_ERASE_CMD = 8'h52;
	localparam logic [7:0] BLOCK_ERASE_CMD = 8'hd8;
	localparam logic [7:0] CHIP_ERASE_CMD_A = 8'hc7;
	localparam logic [7:0] CHIP_ERASE_CMD_B = 8'h60;
	localparam logic [7:0] NO_CMD = 8'h00;

	// ----------------------------------------------------------------
	// geometry, frame layout and reset values
	// ----------------------------------------------------------------
	localparam int PAGE_BYTES = 256;
	localparam logic [24:0] SECTOR_BYTES = 25'h0001000;
	localparam logic [24:0] HALF_BLOCK_BYTES = 25'h0008000;
	localparam logic [24:0] BLOCK_BYTES = 25'h0010000;
	localparam logic [24:0] ARRAY_BYTES = 25'h0200000;
	localparam logic [2:0] ADDR_DONE_BYTES = 3'h4;
	localparam logic [2:0] OPCODE_BYTES = 3'h1;
	localparam int SY_CS = 5;
	localparam int SY_SCLK = 4;
	localparam logic [5:0] SYNC_RST = 6'h20;
	localparam logic [31:0] TIMER_RST = 32'h0;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_PROG, ST_ERASE} flash_state_e;

	typedef enum logic [2:0] {
		OPK_PROG, OPK_QPROG, OPK_SECTOR, OPK_HALF, OPK_BLOCK, OPK_CHIP
	} op_kind_e;

	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic io_line_3;
		logic io_line_2;
		logic io_line_1;
		logic io_line_0;
	} link_in_s;

	typedef struct packed {
		logic io_line_1;
		logic io_line_1_oe_n;
	} link_out_s;

	typedef struct packed {
		logic en;
		logic [23:0] addr;
		logic [7:0] data;
	} prog_wr_s;

	typedef struct packed {
		logic en;
		op_kind_e kind;
		logic [23:0] addr;
	} erase_req_s;

endpackage

// ==== verilog/flash_program_erase.sv ====
// serial flash program/erase sequencer: frame decode, write latch, protection, busy timing
// assumes serial link pins asynchronous to clk_sys, link clock well below clk_sys/4;
// the flash array itself sits outside and takes prog_wr and erase_req
// Function
// - page program: opcode, 24-bit address, data
// - page program needs write latch set
// - data address wraps inside 256-byte page
// - partial program leaves other page bytes
// - program only if select rises on boundary
// - program runs timed cycle showing busy
// - status readable during any busy cycle
// - program end clears write latch
// - protected page refuses program
// - quad program needs quad enable, latch
// - quad program otherwise same as single
// - sector erase sets 4K sector blank
// - every erase needs write latch set
// - erase only if select rises after address
// - block and half block erase codes
// - erase shows busy, clears latch at end
// - protected target refuses sector/block erase
// - chip erase timed, busy, clears latch
// - chip erase select rises after opcode
// - any protection refuses chip erase
// - write enable alone sets latch
// - status byte shifted out msb first
`timescale 1ns/100ps
module flash_program_erase
	import flash_seq_pkg::*;
#(
	parameter int PROG_TIME_NS = 4000,
	parameter int SECTOR_ERASE_TIME_NS = 20000,
	parameter int BLOCK_ERASE_TIME_NS = 40000,
	parameter int ARRAY_ERASE_TIME_NS = 80000
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// serial link
	input wire link_in_s link_in,
	output link_out_s link_out,
	// protection and quad enable configuration
	input wire logic quad_enable_bit,
	input wire logic top_bottom_select,
	input wire logic sector_granularity_select,
	input wire logic protect_level_bit_2,
	input wire logic protect_level_bit_1,
	input wire logic protect_level_bit_0,
	// status
	output logic busy_flag,
	output logic write_enable_latch,
	// array side
	output prog_wr_s prog_wr,
	output erase_req_s erase_req
);

	// ----------------------------------------------------------------
	// cycle counts
	// ----------------------------------------------------------------
	localparam int PROG_RAW = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// the page copy needs one cycle per byte, so the cycle never ends earlier
	localparam int PROG_CYCLES = (PROG_RAW > PAGE_BYTES) ? PROG_RAW : PAGE_BYTES + 1;
	localparam int SECTOR_RAW = (SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SECTOR_CYCLES = (SECTOR_RAW > 1) ? SECTOR_RAW : 2;
	localparam int BLOCK_RAW = (BLOCK_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BLOCK_CYCLES = (BLOCK_RAW > 1) ? BLOCK_RAW : 2;
	localparam int ARRAY_RAW = (ARRAY_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ARRAY_CYCLES = (ARRAY_RAW > 1) ? ARRAY_RAW : 2;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic sclk_prev;
		logic cs_prev;
		logic [2:0] bit_cnt;
		logic [2:0] byte_cnt;
		logic [7:0] shreg;
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [7:0] ptr;
		logic data_seen;
		logic [PAGE_BYTES-1:0] mask;
		logic [7:0] sr_out;
		logic dout;
		logic dout_oe_n;
		flash_state_e st;
		logic busy;
		op_kind_e kind;
		logic [31:0] timer;
		logic [8:0] copy_idx;
		logic wen_latch;
		logic [23:0] op_addr;
		prog_wr_s prog_wr;
		erase_req_s erase_req;
	} state_s;

	state_s q;
	state_s d;
	logic [7:0] page_buf [PAGE_BYTES];
	logic buf_we;
	logic [7:0] buf_idx;
	logic [7:0] buf_data;
	logic cs_rise;
	logic start_prot;
	logic [24:0] cur_prot_len;

	// ----------------------------------------------------------------
	// protection decode
	// ----------------------------------------------------------------
	function automatic logic [24:0] prot_len(input logic granular, input logic [2:0] level);
		logic [24:0] len;
		len = '0;
		if (level != 3'h0) begin
			if (granular) begin
				len = (level >= 3'h4) ? HALF_BLOCK_BYTES : (SECTOR_BYTES << (level - 3'h1));
			end else begin
				len = BLOCK_BYTES << (level - 3'h1);
			end
			if (len > ARRAY_BYTES) begin
				len = ARRAY_BYTES;
			end
		end
		return len;
	endfunction

	// bottom set puts the guarded region at address zero, else at the array top
	function automatic logic prot_hit(input logic [23:0] lo, input logic [23:0] hi,
			input logic bottom, input logic granular, input logic [2:0] level);
		logic [24:0] len;
		logic [24:0] rlo;
		logic [24:0] rhi;
		len = prot_len(granular, level);
		rlo = bottom ? 25'h0 : ARRAY_BYTES - len;
		rhi = bottom ? len : ARRAY_BYTES;
		return (len != 25'h0) && ({1'b0, lo} < rhi) && ({1'b0, hi} >= rlo);
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [2:0] level;
		logic sclk_rise;
		logic sclk_fall;
		logic cs_fall;
		logic cs_low;
		logic quad;
		logic boundary;
		logic [7:0] nxt;
		logic [2:0] bc;
		logic [7:0] status;
		logic [23:0] span_lo;
		logic [23:0] span_hi;
		span_lo = 24'h000000;
		span_hi = 24'h000000;
		level = {protect_level_bit_2, protect_level_bit_1, protect_level_bit_0};
		d = q;
		buf_we = 1'b0;
		buf_idx = q.ptr;
		buf_data = 8'h00;
		d.sync1 = link_in;
		d.sync2 = q.sync1;
		d.sclk_prev = q.sync2[SY_SCLK];
		d.cs_prev = q.sync2[SY_CS];
		d.prog_wr.en = 1'b0;
		d.erase_req.en = 1'b0;
		cs_low = !q.sync2[SY_CS];
		cs_rise = q.sync2[SY_CS] && !q.cs_prev;
		cs_fall = cs_low && q.cs_prev;
		sclk_rise = q.sync2[SY_SCLK] && !q.sclk_prev;
		sclk_fall = !q.sync2[SY_SCLK] && q.sclk_prev;
		quad = (q.opcode == QUAD_PROGRAM_CMD) && (q.byte_cnt != 3'h0);
		boundary = (q.bit_cnt == 3'h0);
		status = {1'b0, sector_granularity_select, top_bottom_select, level,
			q.wen_latch, q.busy};
		nxt = quad ? {q.shreg[3:0], q.sync2[3:0]} : {q.shreg[6:0], q.sync2[0]};
		bc = q.bit_cnt + (quad ? 3'h4 : 3'h1);
		cur_prot_len = prot_len(sector_granularity_select, level);

		// target span of the command held at select rise
		case (q.opcode)
			PAGE_PROGRAM_CMD, QUAD_PROGRAM_CMD: begin
				span_lo = {q.addr[23:8], 8'h00};
				span_hi = {q.addr[23:8], 8'hff};
			end
			SECTOR_ERASE_CMD: begin
				span_lo = {q.addr[23:12], 12'h000};
				span_hi = {q.addr[23:12], 12'hfff};
			end
			HALF_BLOCK_ERASE_CMD: begin
				span_lo = {q.addr[23:15], 15'h0000};
				span_hi = {q.addr[23:15], 15'h7fff};
			end
			BLOCK_ERASE_CMD: begin
				span_lo = {q.addr[23:16], 16'h0000};
				span_hi = {q.addr[23:16], 16'hffff};
			end
			default: begin
				span_lo = 24'h000000;
				span_hi = ARRAY_BYTES[23:0] - 24'h000001;
			end
		endcase
		start_prot = prot_hit(span_lo, span_hi, top_bottom_select,
			sector_granularity_select, level);

		// frame opens: forget the previous command
		if (cs_fall) begin
			d.bit_cnt = 3'h0;
			d.byte_cnt = 3'h0;
			d.data_seen = 1'b0;
			d.opcode = NO_CMD;
			if (!q.busy) begin
				d.mask = '0;
			end
		end

		// shift in on rising link clock
		if (cs_low && sclk_rise) begin
			d.shreg = nxt;
			d.bit_cnt = bc;
			if (bc == 3'h0) begin
				case (q.byte_cnt)
					3'h0: d.opcode = nxt;
					3'h1, 3'h2: d.addr = {q.addr[15:0], nxt};
					3'h3: begin
						d.addr = {q.addr[15:0], nxt};
						d.ptr = nxt;
					end
					default: begin
						d.data_seen = 1'b1;
						// a running cycle still reads the page buffer, so leave it alone
						if (!q.busy && (q.opcode == PAGE_PROGRAM_CMD ||
								q.opcode == QUAD_PROGRAM_CMD)) begin
							buf_we = 1'b1;
							buf_data = nxt;
							d.mask[q.ptr] = 1'b1;
							d.ptr = q.ptr + 8'h01;
						end
					end
				endcase
				if (q.byte_cnt < ADDR_DONE_BYTES) begin
					d.byte_cnt = q.byte_cnt + 3'h1;
				end
			end
		end

		// status out on falling link clock, refreshed at each byte start
		if (cs_low && sclk_fall && q.opcode == READ_STATUS_CMD && q.byte_cnt != 3'h0) begin
			d.dout_oe_n = 1'b0;
			if (boundary) begin
				d.dout = status[7];
				d.sr_out = {status[6:0], 1'b0};
			end else begin
				d.dout = q.sr_out[7];
				d.sr_out = {q.sr_out[6:0], 1'b0};
			end
		end
		if (!cs_low) begin
			d.dout_oe_n = 1'b1;
		end

		// command execution at select rise, only when idle
		if (cs_rise && q.st == ST_IDLE) begin
			case (q.opcode)
				WRITE_ENABLE_CMD: begin
					if (q.byte_cnt == OPCODE_BYTES && boundary) begin
						d.wen_latch = 1'b1;
					end
				end
				PAGE_PROGRAM_CMD, QUAD_PROGRAM_CMD: begin
					if (q.byte_cnt == ADDR_DONE_BYTES && q.data_seen && boundary &&
							q.wen_latch && !start_prot &&
							(q.opcode == PAGE_PROGRAM_CMD || quad_enable_bit)) begin
						d.st = ST_PROG;
						d.busy = 1'b1;
						d.kind = (q.opcode == QUAD_PROGRAM_CMD) ? OPK_QPROG : OPK_PROG;
						d.timer = 32'(PROG_CYCLES);
						d.copy_idx = 9'h000;
						d.op_addr = span_lo;
					end
				end
				SECTOR_ERASE_CMD, HALF_BLOCK_ERASE_CMD, BLOCK_ERASE_CMD: begin
					if (q.byte_cnt == ADDR_DONE_BYTES && !q.data_seen && boundary &&
							q.wen_latch && !start_prot) begin
						d.st = ST_ERASE;
						d.busy = 1'b1;
						d.op_addr = span_lo;
						d.erase_req.en = 1'b1;
						d.erase_req.addr = span_lo;
						if (q.opcode == SECTOR_ERASE_CMD) begin
							d.kind = OPK_SECTOR;
							d.timer = 32'(SECTOR_CYCLES);
						end else begin
							d.kind = (q.opcode == BLOCK_ERASE_CMD) ? OPK_BLOCK : OPK_HALF;
							d.timer = 32'(BLOCK_CYCLES);
						end
						d.erase_req.kind = d.kind;
					end
				end
				CHIP_ERASE_CMD_A, CHIP_ERASE_CMD_B: begin
					if (q.byte_cnt == OPCODE_BYTES && boundary && q.wen_latch &&
							!start_prot) begin
						d.st = ST_ERASE;
						d.busy = 1'b1;
						d.kind = OPK_CHIP;
						d.timer = 32'(ARRAY_CYCLES);
						d.op_addr = 24'h000000;
						d.erase_req.en = 1'b1;
						d.erase_req.kind = OPK_CHIP;
						d.erase_req.addr = 24'h000000;
					end
				end
				default: begin
				end
			endcase
		end

		// self-timed cycle
		case (q.st)
			ST_PROG, ST_ERASE: begin
				d.timer = q.timer - 32'h1;
				// only bytes received in this frame are written, the rest stay as they are
				if (q.st == ST_PROG && !q.copy_idx[8]) begin
					d.copy_idx = q.copy_idx + 9'h001;
					if (q.mask[q.copy_idx[7:0]]) begin
						d.prog_wr.en = 1'b1;
						d.prog_wr.addr = {q.op_addr[23:8], q.copy_idx[7:0]};
						d.prog_wr.data = page_buf[q.copy_idx[7:0]];
					end
				end
				if (q.timer == 32'h1) begin
					d.st = ST_IDLE;
					d.busy = 1'b0;
					d.wen_latch = 1'b0;
				end
			end
			ST_IDLE: begin
			end
			default: begin
				d.st = ST_IDLE;
				d.busy = 1'b0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
			q.sync1 <= SYNC_RST;
			q.sync2 <= SYNC_RST;
			// link clock idles low, so reset must not fake a falling edge
			q.sclk_prev <= 1'b0;
			q.cs_prev <= 1'b1;
			q.dout_oe_n <= 1'b1;
			q.st <= ST_IDLE;
			q.kind <= OPK_PROG;
			q.timer <= TIMER_RST;
		end else begin
			q <= d;
		end
	end

	// page buffer holds no control state, so it needs no reset
	always_ff @(posedge clk_sys) begin
		if (buf_we) begin
			page_buf[buf_idx] <= buf_data;
		end
	end

	assign link_out.io_line_1 = q.dout;
	assign link_out.io_line_1_oe_n = q.dout_oe_n;
	assign busy_flag = q.busy;
	assign write_enable_latch = q.wen_latch;
	assign prog_wr = q.prog_wr;
	assign erase_req = q.erase_req;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	AST_LATCH_CLEARED_AT_END: assert property (@(posedge clk_sys) disable iff (!rstn)
		$fell(q.busy) |-> !q.wen_latch) else $error("write latch still set after cycle");
	AST_START_NEEDS_LATCH: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(q.busy) |-> $past(q.wen_latch)) else $error("cycle started without latch");
	AST_QUAD_NEEDS_ENABLE: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(q.busy) && q.kind == OPK_QPROG |-> $past(quad_enable_bit))
		else $error("quad program without quad enable");
	AST_START_ON_BOUNDARY: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(q.busy) |-> $past(cs_rise) && $past(q.bit_cnt) == 3'h0)
		else $error("cycle started off a byte boundary");
	AST_WRITE_STAYS_IN_PAGE: assert property (@(posedge clk_sys) disable iff (!rstn)
		q.prog_wr.en |-> q.prog_wr.addr[23:8] == q.op_addr[23:8] && q.st == ST_PROG)
		else $error("program write left its page");
	AST_PROG_BUSY_SPAN: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(q.busy) && q.kind == OPK_PROG |-> q.busy [*8] ##1 q.busy)
		else $error("program cycle ended too early");
	AST_CHIP_UNGUARDED: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(q.busy) && q.kind == OPK_CHIP |-> $past(cur_prot_len) == 25'h0)
		else $error("chip erase started with protection set");
	AST_NO_PROTECTED_START: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(q.busy) |-> !$past(start_prot)) else $error("protected target started");
	AST_ERASE_REQUEST: assert property (@(posedge clk_sys) disable iff (!rstn)
		$rose(q.busy) && q.st == ST_ERASE |-> q.erase_req.en && q.erase_req.kind == q.kind)
		else $error("erase started without request");
	AST_NO_RESTART: assert property (@(posedge clk_sys) disable iff (!rstn)
		q.busy && $past(q.busy) |-> q.timer < $past(q.timer))
		else $error("busy cycle restarted");
	AST_STATUS_DRIVE: assert property (@(posedge clk_sys) disable iff (!rstn)
		!q.dout_oe_n |-> q.opcode == READ_STATUS_CMD) else $error("pin driven outside status read");

endmodule

// ==== dv/flash_host_model.sv ====
// host side of the serial link: select, link clock and data lines
// assumes clk_sys from the bench; everything changes on its falling edge
`timescale 1ns/100ps
module flash_host_model
	import flash_seq_pkg::*;
(
	// clock
	input wire logic clk_sys,
	// serial link
	input wire link_out_s link_out,
	output link_in_s link_in
);
	logic cs_n = 1'b1;
	logic sclk = 1'b0;
	logic [3:0] io = 4'h0;

	// io_line_1 is shared: the device wins while its enable is low
	assign link_in = '{cs_n, sclk, io[3], io[2],
		link_out.io_line_1_oe_n ? io[1] : link_out.io_line_1, io[0]};

	// half a 32 ns link period; the link clock stands low outside frames
	task automatic half();
		repeat (4) @(negedge clk_sys);
	endtask

	// data is set up while the link clock is low, taken on its rise
	task automatic tick(input logic [3:0] v, input bit quad);
		if (quad) io = v;
		else io[0] = v[0];
		half();
		sclk = 1'b1;
		half();
		sclk = 1'b0;
	endtask

	// after 32h address and data go a nibble a tick, high nibble first
	task automatic frame(input logic [7:0] b[$], input int extra);
		bit q;
		q = (b[0] === QUAD_PROGRAM_CMD);
		cs_n = 1'b0; // held low over the whole frame
		foreach (b[i]) begin
			if (q && i > 0) begin
				tick(b[i][7:4], 1'b1);
				tick(b[i][3:0], 1'b1);
			end else begin
				for (int k = 7; k >= 0; k--) tick({3'h0, b[i][k]}, 1'b0);
			end
		end
		repeat (extra) tick(4'h1, 1'b0);
		half();
		cs_n = 1'b1; // off a byte boundary only when extra bits are asked
		io = ~io; // released lines must not keep their last value
		repeat (2) half();
	endtask

	// sampled late in the high phase, clear of the device's update delay
	task automatic status(output logic [7:0] s);
		cs_n = 1'b0;
		for (int k = 7; k >= 0; k--) tick({3'h0, READ_STATUS_CMD[k]}, 1'b0);
		for (int k = 7; k >= 0; k--) begin
			half();
			sclk = 1'b1;
			half();
			s[k] = link_in.io_line_1;
			sclk = 1'b0;
		end
		half();
		cs_n = 1'b1;
		repeat (2) half();
	endtask
endmodule

// ==== dv/flash_program_erase_tb_top.sv ====
// self-checking bench of the program/erase sequencer
// assumes the host model above; array side is watched, not modelled
`timescale 1ns/100ps
module flash_program_erase_tb_top
	import flash_seq_pkg::*;
;
	localparam int PT = 1100;
	localparam int ET = 200;
	localparam int PROG_CYC = ((PT + 3) / 4 > 257) ? (PT + 3) / 4 : 257;
	localparam int ERASE_CYC = (ET + 3) / 4;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	link_in_s link_in;
	link_out_s link_out;
	logic quad_enable_bit = 1'b0;
	logic top_bottom_select = 1'b0;
	logic sector_granularity_select = 1'b0;
	logic protect_level_bit_2 = 1'b0;
	logic protect_level_bit_1 = 1'b0;
	logic protect_level_bit_0 = 1'b0;
	logic busy_flag;
	logic write_enable_latch;
	prog_wr_s prog_wr;
	erase_req_s erase_req;
	prog_wr_s pq[$];
	erase_req_s eq[$];
	int busy_n;
	int err_total = 0;
	int checks = 0;
	logic [7:0] s;

	always #2 clk_sys = ~clk_sys;

	flash_program_erase #(.PROG_TIME_NS(PT), .SECTOR_ERASE_TIME_NS(ET),
		.BLOCK_ERASE_TIME_NS(ET), .ARRAY_ERASE_TIME_NS(ET)) dut (.clk_sys(clk_sys),
		.rstn(rstn), .link_in(link_in), .link_out(link_out),
		.quad_enable_bit(quad_enable_bit), .top_bottom_select(top_bottom_select),
		.sector_granularity_select(sector_granularity_select),
		.protect_level_bit_2(protect_level_bit_2), .protect_level_bit_1(protect_level_bit_1),
		.protect_level_bit_0(protect_level_bit_0), .busy_flag(busy_flag),
		.write_enable_latch(write_enable_latch), .prog_wr(prog_wr), .erase_req(erase_req));

	flash_host_model host (.clk_sys(clk_sys), .link_out(link_out), .link_in(link_in));

	always @(posedge clk_sys) begin
		if (prog_wr.en === 1'b1) pq.push_back(prog_wr);
		if (erase_req.en === 1'b1) eq.push_back(erase_req);
		if (busy_flag === 1'b1) busy_n++;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy_flag !== 1'b0 && n < 40000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 40000) begin
			err_total++;
			$display("Error at %0t: busy never cleared", $time);
		end
	endtask

	task automatic run(input logic [7:0] b[$], input int extra, input logic exp_busy);
		pq.delete();
		eq.delete();
		busy_n = 0;
		host.frame(b, extra);
		chk({31'h0, busy_flag}, {31'h0, exp_busy});
		wait_idle();
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_refuse();
		host.status(s);
		chk({24'h0, s}, 32'h00);
		run('{8'h02, 8'h00, 8'h10, 8'h00, 8'haa}, 0, 1'b0);
		run('{WRITE_ENABLE_CMD}, 0, 1'b0);
		chk({31'h0, write_enable_latch}, 32'h1);
		host.status(s);
		chk({24'h0, s}, 32'h02);
		run('{8'h02, 8'h00, 8'h10, 8'h00, 8'haa}, 3, 1'b0);
		run('{8'h02, 8'h00, 8'h10, 8'h00}, 0, 1'b0);
		run('{8'h20, 8'h00, 8'h10, 8'h00, 8'h11}, 0, 1'b0);
		run('{8'hc7}, 2, 1'b0);
		run('{8'h32, 8'h00, 8'h10, 8'h00, 8'haa}, 0, 1'b0);
		chk(pq.size() + eq.size(), 0);
		chk({31'h0, write_enable_latch}, 32'h1);
		$display("done t_refuse");
	endtask

	task automatic t_prog();
		logic [7:0] off[4] = '{8'h00, 8'h01, 8'hfe, 8'hff};
		logic [7:0] dat[4] = '{8'hc3, 8'hd4, 8'ha1, 8'hb2};
		run('{8'h02, 8'h00, 8'h12, 8'hfe, 8'ha1, 8'hb2, 8'hc3, 8'hd4}, 0, 1'b1);
		chk(busy_n, PROG_CYC);
		chk({31'h0, write_enable_latch}, 32'h0);
		chk(pq.size(), 4);
		foreach (off[i]) chk({pq[i].addr, pq[i].data}, {16'h0012, off[i], dat[i]});
		$display("done t_prog");
	endtask

	task automatic t_busy();
		run('{WRITE_ENABLE_CMD}, 0, 1'b0);
		pq.delete();
		host.frame('{8'h02, 8'h00, 8'h20, 8'h00, 8'h5a}, 0);
		host.status(s);
		chk({24'h0, s}, 32'h03);
		host.frame('{CHIP_ERASE_CMD_B}, 0);
		wait_idle();
		chk(eq.size(), 0);
		chk(pq.size(), 1);
		$display("done t_busy");
	endtask

	task automatic t_wrap();
		logic [7:0] b[$];
		b = '{8'h02, 8'h00, 8'h34, 8'h02};
		for (int i = 0; i < 257; i++) b.push_back(i < 256 ? i[7:0] : 8'hee);
		run('{WRITE_ENABLE_CMD}, 0, 1'b0);
		run(b, 0, 1'b1);
		chk(pq.size(), 256);
		for (int o = 0; o < pq.size(); o++)
			chk({pq[o].addr, pq[o].data}, {16'h0034, o[7:0], o == 2 ? 8'hee : o[7:0] - 8'h2});
		$display("done t_wrap");
	endtask

	task automatic t_quad();
		quad_enable_bit = 1'b1;
		run('{WRITE_ENABLE_CMD}, 0, 1'b0);
		run('{8'h32, 8'h00, 8'h56, 8'h10, 8'h3c, 8'ha5}, 0, 1'b1);
		chk(busy_n, PROG_CYC);
		chk({31'h0, write_enable_latch}, 32'h0);
		chk(pq.size(), 2);
		chk({pq[0].addr, pq[0].data}, {24'h005610, 8'h3c});
		chk({24'h0, pq[1].data}, {24'h0, 8'ha5});
		quad_enable_bit = 1'b0;
		$display("done t_quad");
	endtask

	task automatic t_erase();
		logic [7:0] op[5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
		op_kind_e kd[5] = '{OPK_SECTOR, OPK_HALF, OPK_BLOCK, OPK_CHIP, OPK_CHIP};
		logic [23:0] ad[5] = '{24'h123000, 24'h120000, 24'h120000, 24'h0, 24'h0};
		logic [7:0] b[$];
		foreach (op[i]) begin
			b = '{op[i]};
			if (i < 3) b = {b, 8'h12, 8'h34, 8'h56};
			run('{WRITE_ENABLE_CMD}, 0, 1'b0);
			run(b, 0, 1'b1);
			chk(eq.size(), 1);
			chk({5'h0, eq[0].kind, eq[0].addr}, {5'h0, kd[i], ad[i]});
			chk(busy_n, ERASE_CYC);
			chk({31'h0, write_enable_latch}, 32'h0);
		end
		$display("done t_erase");
	endtask

	// lowest 64K protected from the bottom
	task automatic t_protect();
		top_bottom_select = 1'b1;
		protect_level_bit_0 = 1'b1;
		run('{WRITE_ENABLE_CMD}, 0, 1'b0);
		host.status(s);
		chk({24'h0, s}, 32'h26);
		run('{8'h02, 8'h00, 8'h01, 8'h00, 8'h77}, 0, 1'b0);
		run('{8'h20, 8'h00, 8'h10, 8'h00}, 0, 1'b0);
		run('{8'hc7}, 0, 1'b0);
		chk({31'h0, write_enable_latch}, 32'h1);
		run('{8'h20, 8'h10, 8'h00, 8'h00}, 0, 1'b1);
		chk(eq.size(), 1);
		// fine granularity: only the lowest 4K stays guarded
		sector_granularity_select = 1'b1;
		run('{WRITE_ENABLE_CMD}, 0, 1'b0);
		run('{8'h20, 8'h00, 8'h00, 8'h00}, 0, 1'b0);
		run('{8'h20, 8'h00, 8'h10, 8'h00}, 0, 1'b1);
		chk({5'h0, eq[0].kind, eq[0].addr}, {5'h0, OPK_SECTOR, 24'h001000});
		sector_granularity_select = 1'b0;
		top_bottom_select = 1'b0;
		protect_level_bit_0 = 1'b0;
		$display("done t_protect");
	endtask

	initial begin
		repeat (8) @(negedge clk_sys);
		rstn = 1'b1;
		repeat (2) @(negedge clk_sys);
		t_refuse();
		t_prog();
		t_busy();
		t_wrap();
		t_quad();
		t_erase();
		t_protect();
		complete_run();
	end

	// the whole sequence needs about 25k cycles; over three times that means a hang
	initial begin
		#360000;
		err_total++;
		complete_run();
	end
endmodule
